//--- core/supply_fault_pkg.sv
package supply_fault_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	// Sleep input must stay low this long to count as a reset pulse
	localparam int SLEEP_RESET_NS = 1000;
	localparam int SLEEP_RESET_CYC = (SLEEP_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------
	// Dither profile
	// ----------------------------------------
	localparam int DITHER_STEPS = 14;
	localparam int DITHER_LOW_KHZ = 9000;
	localparam int DITHER_HIGH_KHZ = 11000;
	localparam int DITHER_CENTER_KHZ = 10000;
	// Dwell on each step, in core cycles
	localparam int DITHER_DWELL_CYC = 64;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic RST_SUMMARY_FLAG = 1'b1;
	localparam logic RST_MOTOR_LOW_FLAG = 1'b0;
	localparam logic RST_PUMP_LOW_FLAG = 1'b0;
	localparam logic RST_POWER_ON_FLAG = 1'b0;
	localparam logic RST_DITHER_DISABLE = 1'b1;
	localparam logic RST_FAULT_N = 1'b0;
	localparam int STEP_W = 4;
endpackage

//--- core/dither_if.sv
`timescale 1ns/1ns
interface dither_if;
	logic enable;
	logic [3:0] step;
	logic [15:0] freq_khz;
	modport ctrl (output enable, input step, input freq_khz);
	modport gen (input enable, output step, output freq_khz);
endinterface

//--- core/dither_gen.sv
`timescale 1ns/1ns
module dither_gen
	import supply_fault_pkg::*;
#(
	parameter int DWELL = DITHER_DWELL_CYC
) (
	input wire logic clk_in,  // Core clock
	input wire logic rst_n,  // Synchronised reset
	dither_if.gen dif  // Dither control
);
	typedef struct packed {
		logic [15:0] dwell;
		logic [3:0] step;
		logic up;
	} gen_state_t;

	gen_state_t cur, next_cur;

	// ----------------------------------------
	// Triangle walk
	// ----------------------------------------
	always_comb begin
		next_cur = cur;
		if (!dif.enable) begin
			next_cur.dwell = 16'h0000;
			next_cur.step = 4'(DITHER_STEPS / 2);
			next_cur.up = 1'b1;
		end else if (cur.dwell == 16'(DWELL - 1)) begin  // [RULE17]
			next_cur.dwell = 16'h0000;
			if (cur.up) begin
				if (cur.step == 4'(DITHER_STEPS - 1)) begin
					next_cur.up = 1'b0;
					next_cur.step = cur.step - 4'h1;
				end else begin
					next_cur.step = cur.step + 4'h1;
				end
			end else begin
				if (cur.step == 4'h0) begin
					next_cur.up = 1'b1;
					next_cur.step = 4'h1;
				end else begin
					next_cur.step = cur.step - 4'h1;
				end
			end
		end else begin
			next_cur.dwell = cur.dwell + 16'h0001;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '{dwell: 16'h0000, step: 4'(DITHER_STEPS / 2), up: 1'b1};
		end else begin
			cur <= next_cur;
		end
	end

	assign dif.step = cur.step;
	// Nominal frequency: walks from low to high limit in equal steps
	assign dif.freq_khz = dif.enable ?
		16'(DITHER_LOW_KHZ + (int'(cur.step) * (DITHER_HIGH_KHZ - DITHER_LOW_KHZ))
		/ (DITHER_STEPS - 1)) : 16'(DITHER_CENTER_KHZ);  // [RULE17]

	chk_step_in_range: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE17]
		cur.step < 4'(DITHER_STEPS))
		else $error("dither step out of range");
	chk_step_moves_one: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE17]
		(dif.enable && $past(dif.enable) && cur.step != $past(cur.step))
		|-> (cur.step == $past(cur.step) + 4'h1 || cur.step == $past(cur.step) - 4'h1))
		else $error("dither step jumped");
	cov_dither_top: cover property (@(posedge clk_in) disable iff (!rst_n)
		dif.enable && cur.step == 4'(DITHER_STEPS - 1));
endmodule

//--- core/supply_fault_supervisor.sv
`timescale 1ns/1ns
// Functional notes
// RULE1: Motor supply low: outputs off, pump off, fault
// RULE2: Motor supply above rising threshold: resume driving
// RULE3: SPI: core alive, summary and motor flags set
// RULE4: Motor recovery releases fault, clears summary flag
// RULE5: Motor flag latched until clear or sleep pulse
// RULE6: Below core reset: flags zero, fault pin high
// RULE7: Power-up: summary set, fault low, motor flag clear
// RULE8: Pump low: outputs off, pump runs, fault, flags
// RULE9: Pump recovery resumes; pump flag stays latched
// RULE10: Logic supply low: outputs, pump off, no fault
// RULE11: Logic supply recovery restarts driving automatically
// RULE12: Power-on flag zero after logic supply rises
// RULE13: Clear command latches power-on flag to one
// RULE14: Dither off after reset; cleared bit enables it
// RULE15: Silent step decay forces dither off
// RULE16: Hardware pin interface keeps dither off
// RULE17: Triangle profile, equal steps, low to high
// RULE18: Fault pin low while any reported supply fault
module supply_fault_supervisor
	import supply_fault_pkg::*;
#(
	parameter int SLEEP_PULSE_CYC = SLEEP_RESET_CYC,
	parameter int DWELL = DITHER_DWELL_CYC
) (
	input wire logic clk_in,  // 125 MHz core clock
	input wire logic rstn_in,  // Core reset, low below core reset level
	input wire logic motor_low_in,  // Motor supply below lockout (hysteresis in comparator)
	input wire logic pump_low_in,  // Pump rail below undervoltage level
	input wire logic logic_low_in,  // Logic supply below lockout
	input wire logic sleep_n_input_in,  // Sleep pin, active low
	input wire logic spi_mode_in,  // High: SPI configuration, low: pin strapped
	input wire logic clear_faults_cmd_in,  // One-cycle clear-faults write
	input wire logic dither_disable_bit_in,  // Dither-disable bit write data
	input wire logic dither_disable_wr_in,  // One-cycle write strobe for that bit
	input wire logic silent_decay_in,  // Silent step decay mode active
	output logic fault_out_n_out,  // Fault pin drive value, low = fault
	output logic fault_oe_n_out,  // Fault pin enable, low while pulling low
	output logic outputs_enable_out,  // High: bridges may drive, low: Hi-Z
	output logic pump_enable_out,  // Charge pump on
	output logic summary_flag_out,  // Summary fault flag
	output logic motor_supply_low_flag_out,  // Latched motor supply low flag
	output logic pump_rail_low_flag_out,  // Latched pump rail low flag
	output logic logic_power_on_flag_out,  // Power-on flag
	output logic spi_ready_out,  // Core up and SPI available
	output logic dither_active_out,  // Dithering running
	output logic [3:0] dither_step_out,  // Current dither step
	output logic [15:0] clk_freq_khz_out  // Nominal digital clock frequency
);
	// ----------------------------------------
	// Reset and input synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	wire rst_n = rst_sync[1];

	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
	} sync_t;
	sync_t sy;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			// Motor supply counts as low until the pin is seen, so powerup is never skipped
			sy <= '{s1: 4'h9, s2: 4'h9};
		end else begin
			sy.s1 <= {sleep_n_input_in, logic_low_in, pump_low_in, motor_low_in};
			sy.s2 <= sy.s1;
		end
	end
	wire motor_low = sy.s2[0];
	wire pump_low = sy.s2[1];
	wire logic_low = sy.s2[2];
	wire sleep_n = sy.s2[3];

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_POWERUP,
		ST_RUN,
		ST_LOCKOUT
	} mode_t;

	typedef struct packed {
		mode_t mode;
		logic summary;
		logic motor_flag;
		logic pump_flag;
		logic por_flag;
		logic dis_dither;
		logic sleep_prev;
		logic [15:0] sleep_cnt;
		logic sleep_pulse;
		logic fault_n;
		logic out_en;
		logic pump_en;
	} sup_state_t;

	sup_state_t cur, next_cur;

	wire supply_fault = motor_low | pump_low;
	wire clear_req = clear_faults_cmd_in | cur.sleep_pulse;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// What the pin and the summary flag report; a logic supply dip is not one
	function automatic logic reported_fault(input logic sf, input mode_t m);
		return sf | (m == ST_POWERUP);
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_cur = cur;
		next_cur.sleep_prev = sleep_n;
		next_cur.sleep_pulse = 1'b0;
		// Sleep reset pulse: low for the minimum width, acted on at rising edge
		// The count saturates, so a very long sleep still yields one pulse
		if (!sleep_n) begin
			if (cur.sleep_cnt != 16'hFFFF) begin
				next_cur.sleep_cnt = cur.sleep_cnt + 16'h0001;
			end
		end else begin
			next_cur.sleep_cnt = 16'h0000;
			if (!cur.sleep_prev && cur.sleep_cnt >= 16'(SLEEP_PULSE_CYC)) begin
				next_cur.sleep_pulse = 1'b1;
			end
		end

		case (cur.mode)
			ST_POWERUP: begin
				// Summary stays set until motor supply first passes rising level
				if (!motor_low) begin  // [RULE7]
					next_cur.mode = ST_RUN;
				end
			end
			ST_RUN: begin
				if (motor_low) begin
					next_cur.mode = ST_LOCKOUT;  // [RULE1]
				end
			end
			ST_LOCKOUT: begin
				if (!motor_low) begin
					next_cur.mode = ST_RUN;  // [RULE2]
				end
			end
			default: begin
				next_cur.mode = ST_POWERUP;
			end
		endcase

		// Flags: clear first so a same-cycle set wins
		if (clear_req) begin
			next_cur.motor_flag = 1'b0;  // [RULE5]
			next_cur.pump_flag = 1'b0;  // [RULE9]
			next_cur.por_flag = 1'b1;  // [RULE13]
		end
		if (spi_mode_in && motor_low && cur.mode != ST_POWERUP) begin
			next_cur.motor_flag = 1'b1;  // [RULE3]
		end
		if (spi_mode_in && pump_low) begin
			next_cur.pump_flag = 1'b1;  // [RULE8]
		end
		// Power-on flag is held at zero while the logic supply is low in SPI mode
		if (spi_mode_in && logic_low) begin
			next_cur.por_flag = 1'b0;  // [RULE12]
		end

		// Summary follows live supply faults; powerup holds it high
		next_cur.summary = spi_mode_in &
			reported_fault(supply_fault, next_cur.mode);  // [RULE3] [RULE4] [RULE8]

		if (dither_disable_wr_in && spi_mode_in) begin
			next_cur.dis_dither = dither_disable_bit_in;  // [RULE14]
		end

		// Logic supply low is not reported on the fault pin
		next_cur.fault_n = !reported_fault(supply_fault, next_cur.mode);  // [RULE18]
		// Bridges wait for RUN, so powerup and lockout never drive them
		next_cur.out_en = !(supply_fault | logic_low) &&
			next_cur.mode == ST_RUN;  // [RULE1] [RULE8] [RULE10] [RULE11]
		// Pump keeps running through a pump rail dip so the rail can recover
		next_cur.pump_en = !(motor_low | logic_low);  // [RULE1] [RULE8] [RULE10]
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			// Core reset: released from fault pin until powerup state registers
			cur <= '{mode: ST_POWERUP, summary: RST_SUMMARY_FLAG,
				motor_flag: RST_MOTOR_LOW_FLAG, pump_flag: RST_PUMP_LOW_FLAG,
				por_flag: RST_POWER_ON_FLAG, dis_dither: RST_DITHER_DISABLE,
				sleep_prev: 1'b1, sleep_cnt: 16'h0000, sleep_pulse: 1'b0,
				fault_n: RST_FAULT_N, out_en: 1'b0, pump_en: 1'b0};  // [RULE7] [RULE14]
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------
	// Dither
	// ----------------------------------------
	dither_if dif ();
	assign dif.enable = spi_mode_in && !cur.dis_dither &&
		!silent_decay_in && rst_n;  // [RULE15] [RULE16]
	dither_gen #(.DWELL(DWELL)) u_dither (
		.clk_in(clk_in),
		.rst_n(rst_n),
		.dif(dif.gen)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Below core reset flags, ready and enables read zero, dither sits at its centre step and frequency, and the pin floats high
	assign summary_flag_out = rst_n & cur.summary;  // [RULE6]
	assign motor_supply_low_flag_out = rst_n & cur.motor_flag;  // [RULE6]
	assign pump_rail_low_flag_out = rst_n & cur.pump_flag;
	assign logic_power_on_flag_out = rst_n & cur.por_flag;
	assign spi_ready_out = rst_n;  // [RULE6]
	assign fault_out_n_out = 1'b0;
	assign fault_oe_n_out = !rst_n | cur.fault_n;  // [RULE6] [RULE18]
	assign outputs_enable_out = cur.out_en;
	assign pump_enable_out = cur.pump_en;
	assign dither_active_out = dif.enable;
	assign dither_step_out = dif.step;
	assign clk_freq_khz_out = dif.freq_khz;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_motor_low_off: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE1]
		motor_low |=> (!outputs_enable_out && !pump_enable_out && !fault_oe_n_out))
		else $error("motor low did not lock out");
	chk_lockout_no_drive: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE1]
		(cur.mode != ST_RUN) |-> !outputs_enable_out)
		else $error("bridges driven outside run");
	chk_motor_resume: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE2]
		(cur.mode == ST_LOCKOUT && !motor_low && !pump_low && !logic_low) ##1
		(!motor_low && !pump_low && !logic_low) |=> outputs_enable_out)
		else $error("no resume after motor recovery");

	chk_motor_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE3]
		(spi_mode_in && motor_low && cur.mode == ST_RUN)
		|=> (motor_supply_low_flag_out && summary_flag_out))
		else $error("motor flags not set");
	chk_pin_mode_quiet: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE3]
		(!spi_mode_in && !motor_supply_low_flag_out && !pump_rail_low_flag_out)
		|=> (!summary_flag_out && !motor_supply_low_flag_out && !pump_rail_low_flag_out))
		else $error("flag set in pin mode");
	chk_summary_drop: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE4]
		(cur.mode != ST_POWERUP && !motor_low && !pump_low)
		|=> (!summary_flag_out && fault_oe_n_out))
		else $error("summary not released");

	chk_flag_hold: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE5]
		(motor_supply_low_flag_out && !clear_req) |=> motor_supply_low_flag_out)
		else $error("motor flag lost without clear");
	chk_clear_flags: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE5]
		(clear_req && !motor_low && !pump_low)
		|=> (!motor_supply_low_flag_out && !pump_rail_low_flag_out))
		else $error("flags survived a clear");
	chk_sleep_width: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE5]
		cur.sleep_pulse |-> ($past(cur.sleep_cnt) >= 16'(SLEEP_PULSE_CYC)))
		else $error("sleep pulse too short");
	chk_sleep_once: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE5]
		cur.sleep_pulse |=> !cur.sleep_pulse)
		else $error("sleep pulse repeated");

	// No disable here: this one watches what the core shows while held in reset
	chk_core_off: assert property (@(posedge clk_in)  // [RULE6]
		!rst_n |-> (!summary_flag_out && !motor_supply_low_flag_out && fault_oe_n_out
		&& !spi_ready_out && !outputs_enable_out))
		else $error("core not quiet in reset");
	// The release edge still samples the gated outputs, hence rst_n in the antecedent
	chk_powerup_fault: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE7]
		(cur.mode == ST_POWERUP && rst_n)
		|-> (!fault_oe_n_out && !motor_supply_low_flag_out))
		else $error("powerup fault state wrong");

	chk_pump_low: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE8]
		(pump_low && !motor_low && !logic_low)
		|=> (!outputs_enable_out && pump_enable_out && !fault_oe_n_out))
		else $error("pump low handling wrong");
	chk_pump_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE8]
		(spi_mode_in && pump_low) |=> (pump_rail_low_flag_out && summary_flag_out))
		else $error("pump flags not set");
	chk_pump_resume: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE9]
		(cur.mode == ST_RUN && !motor_low && !pump_low && !logic_low)
		|=> (outputs_enable_out && fault_oe_n_out))
		else $error("no resume after pump recovery");
	chk_pump_flag_hold: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE9]
		(pump_rail_low_flag_out && !clear_req) |=> pump_rail_low_flag_out)
		else $error("pump flag lost without clear");

	chk_logic_low: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE10]
		(logic_low && !supply_fault && cur.mode == ST_RUN)
		|=> (!outputs_enable_out && !pump_enable_out && fault_oe_n_out))
		else $error("logic low handling wrong");
	chk_logic_resume: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE11]
		($past(logic_low) && !logic_low && !supply_fault && cur.mode == ST_RUN)
		|=> (outputs_enable_out && pump_enable_out))
		else $error("no restart after logic recovery");
	chk_por_zero: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE12]
		(spi_mode_in && logic_low) |=> !logic_power_on_flag_out)
		else $error("power-on flag not held at zero");
	chk_por_clear: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE13]
		(clear_faults_cmd_in && !(spi_mode_in && logic_low)) |=> logic_power_on_flag_out)
		else $error("power-on flag not set by clear");

	chk_dither_reset: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE14]
		$rose(rst_n) |-> !dither_active_out)
		else $error("dither on after reset");
	chk_dither_write: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE14]
		(dither_disable_wr_in && spi_mode_in && !dither_disable_bit_in) ##1
		(spi_mode_in && !silent_decay_in) |-> dither_active_out)
		else $error("dither not enabled by write");
	chk_dither_forced: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE15]
		(silent_decay_in || !spi_mode_in) |-> !dither_active_out)
		else $error("dither not forced off");
	chk_dither_refused: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE16]
		(dither_disable_wr_in && !spi_mode_in) |=> $stable(cur.dis_dither))
		else $error("dither bit written in pin mode");

	chk_fault_reported: assert property (@(posedge clk_in) disable iff (!rst_n)  // [RULE18]
		(motor_low || pump_low) |=> !fault_oe_n_out)
		else $error("fault pin released during supply fault");

	cov_motor_lockout: cover property (@(posedge clk_in) disable iff (!rst_n)
		cur.mode == ST_RUN ##1 cur.mode == ST_LOCKOUT ##[1:50] cur.mode == ST_RUN);
	cov_sleep_clear: cover property (@(posedge clk_in) disable iff (!rst_n)
		cur.sleep_pulse && cur.motor_flag);
	cov_dither_on: cover property (@(posedge clk_in) disable iff (!rst_n)
		dither_active_out);
	cov_logic_dip: cover property (@(posedge clk_in) disable iff (!rst_n)
		cur.mode == ST_RUN && logic_low);
endmodule

//--- sim/host_model.sv
`timescale 1ns/1ns
module host_model (
	input wire logic fault_drive_in,  // Device drive value
	input wire logic fault_oe_n_in,  // Device enable, low while pulling
	output logic fault_line_out  // Wire level seen by the host
);
	// Open-drain line: the host pull-up wins once the device lets go
	assign fault_line_out = fault_oe_n_in ? 1'b1 : fault_drive_in;
endmodule

//--- sim/supply_fault_supervisor_tb.sv
`timescale 1ns/1ns
module supply_fault_supervisor_tb;
	import supply_fault_pkg::*;
	localparam int PULSE = 4;
	localparam int DW = 4;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic motor_low_in = 1'b1;
	logic pump_low_in = 1'b0;
	logic logic_low_in = 1'b0;
	logic sleep_n_in = 1'b1;
	logic spi_mode_in = 1'b1;
	logic clear_in = 1'b0;
	logic dis_bit_in = 1'b1;
	logic dis_wr_in = 1'b0;
	logic silent_in = 1'b0;
	logic drive_n, oe_n, out_en, pump_en, summary, mflag, pflag, por, ready, dith, line;
	logic [3:0] step;
	logic [3:0] prev;
	logic [3:0] lo;
	logic [3:0] hi;
	logic [15:0] freq;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
	supply_fault_supervisor #(.SLEEP_PULSE_CYC(PULSE), .DWELL(DW)) dut (
		.clk_in(clk_in), .rstn_in(rstn_in), .motor_low_in(motor_low_in),
		.pump_low_in(pump_low_in), .logic_low_in(logic_low_in),
		.sleep_n_input_in(sleep_n_in), .spi_mode_in(spi_mode_in),
		.clear_faults_cmd_in(clear_in), .dither_disable_bit_in(dis_bit_in),
		.dither_disable_wr_in(dis_wr_in), .silent_decay_in(silent_in),
		.fault_out_n_out(drive_n), .fault_oe_n_out(oe_n), .outputs_enable_out(out_en),
		.pump_enable_out(pump_en), .summary_flag_out(summary),
		.motor_supply_low_flag_out(mflag), .pump_rail_low_flag_out(pflag),
		.logic_power_on_flag_out(por), .spi_ready_out(ready), .dither_active_out(dith),
		.dither_step_out(step), .clk_freq_khz_out(freq));
	host_model host (.fault_drive_in(drive_n), .fault_oe_n_in(oe_n), .fault_line_out(line));
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic check1(input string what, input logic seen, input logic exp);
		check(what, {15'h0000, seen}, {15'h0000, exp});
	endtask
	task automatic end_sim();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic pins(input logic e_out, input logic e_pump, input logic e_line);
		check1("outputs enable", out_en, e_out);
		check1("pump enable", pump_en, e_pump);
		check1("fault line", line, e_line);
	endtask
	task automatic clear_cmd();
		clear_in = 1'b1;
		tick(1);
		clear_in = 1'b0;
		tick(1);
	endtask
	task automatic dwrite(input logic v);
		dis_bit_in = v;
		dis_wr_in = 1'b1;
		tick(1);
		dis_wr_in = 1'b0;
		tick(2);
	endtask
	// Supply pins pass a two-stage synchroniser before the registered outputs
	task automatic supply(input logic m, input logic p, input logic l);
		motor_low_in = m;
		pump_low_in = p;
		logic_low_in = l;
		tick(4);
	endtask
	task automatic release_reset();
		rstn_in = 1'b1;
		for (int i = 0; i < 10 && ready !== 1'b1; i++) tick(1);
		if (ready !== 1'b1) begin
			n_mismatch++;
			end_sim();
		end
		tick(1);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		tick(3);
		check1("summary in reset", summary, 1'b0);
		check1("line in reset", line, 1'b1);
		check1("ready in reset", ready, 1'b0);
		tick(3);
		release_reset();
		pins(1'b0, 1'b0, 1'b0);
		check1("summary", summary, 1'b1);
		check1("motor flag", mflag, 1'b0);
		supply(1'b0, 1'b0, 1'b0);
		pins(1'b1, 1'b1, 1'b1);
		check1("motor flag", mflag, 1'b0);
		check1("dither", dith, 1'b0);
		check("freq", freq, 16'(DITHER_CENTER_KHZ));
		clear_cmd();
		check1("por flag", por, 1'b1);
		supply(1'b1, 1'b0, 1'b0);
		pins(1'b0, 1'b0, 1'b0);
		check1("summary", summary, 1'b1);
		check1("motor flag", mflag, 1'b1);
		check1("ready", ready, 1'b1);
		supply(1'b0, 1'b0, 1'b0);
		pins(1'b1, 1'b1, 1'b1);
		check1("summary", summary, 1'b0);
		check1("motor flag", mflag, 1'b1);
		clear_cmd();
		check1("motor flag", mflag, 1'b0);
		supply(1'b0, 1'b1, 1'b0);
		pins(1'b0, 1'b1, 1'b0);
		check1("summary", summary, 1'b1);
		check1("pump flag", pflag, 1'b1);
		supply(1'b1, 1'b1, 1'b0);
		supply(1'b0, 1'b1, 1'b0);
		check1("line one fault left", line, 1'b0);
		supply(1'b0, 1'b0, 1'b0);
		pins(1'b1, 1'b1, 1'b1);
		check1("pump flag", pflag, 1'b1);
		sleep_n_in = 1'b0;
		tick(PULSE + 2);
		sleep_n_in = 1'b1;
		tick(5);
		check1("pump flag", pflag, 1'b0);
		check1("motor flag", mflag, 1'b0);
		supply(1'b0, 1'b0, 1'b1);
		pins(1'b0, 1'b0, 1'b1);
		supply(1'b0, 1'b0, 1'b0);
		pins(1'b1, 1'b1, 1'b1);
		check1("por flag", por, 1'b0);
		clear_cmd();
		check1("por flag", por, 1'b1);
		dwrite(1'b0);
		check1("dither", dith, 1'b1);
		prev = step;
		lo = 4'hF;
		hi = 4'h0;
		for (int i = 0; i < 30 * DW; i++) begin
			tick(1);
			if (step !== prev) begin
				check1("step move", (step == prev + 1) || (prev == step + 1), 1'b1);
				check("freq", freq, 16'(9000 + int'(step) * 2000 / 13));
				prev = step;
				lo = (step < lo) ? step : lo;
				hi = (step > hi) ? step : hi;
			end
		end
		check("lowest step", {12'h000, lo}, 16'h0000);
		check("highest step", {12'h000, hi}, 16'h000D);
		silent_in = 1'b1;
		tick(2);
		check1("dither silent", dith, 1'b0);
		silent_in = 1'b0;
		spi_mode_in = 1'b0;
		tick(2);
		check1("dither pin mode", dith, 1'b0);
		spi_mode_in = 1'b1;
		dwrite(1'b1);
		spi_mode_in = 1'b0;
		dwrite(1'b0);
		spi_mode_in = 1'b1;
		tick(2);
		check1("dither refused", dith, 1'b0);
		dwrite(1'b0);
		supply(1'b1, 1'b0, 1'b0);
		rstn_in = 1'b0;
		tick(2);
		check1("summary in reset", summary, 1'b0);
		check1("motor flag in reset", mflag, 1'b0);
		check1("line in reset", line, 1'b1);
		check1("ready in reset", ready, 1'b0);
		release_reset();
		check1("dither after reset", dith, 1'b0);
		check1("motor flag", mflag, 1'b0);
		end_sim();
	end
endmodule
